// File: mar_daq_sink.sv
// Purpose: acquisition-side sink for the readout word stream
// Assumes: no back-pressure, a word is taken on every out_valid
// Notes: keeps counters and the last word for the bench to inspect
`timescale 1ns/1ps
module mar_daq_sink
	import mar_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic valid_i,
	input wire logic [MAR_OUT_W-1:0] data_i,
	input wire logic [MAR_NB_W-1:0] nbits_i,
	input wire logic [5:0] chan_i,
	input wire logic sof_i,
	input wire logic eof_i,
	output logic [31:0] cnt_o,
	output logic [31:0] sof_cnt_o,
	output logic [31:0] eof_cnt_o,
	output logic [MAR_OUT_W-1:0] data_o,
	output logic [MAR_NB_W-1:0] nbits_o,
	output logic [5:0] chan_o
);
	// ------------------------------------------------------------
	// word capture
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_o <= 32'h0;
			sof_cnt_o <= 32'h0;
			eof_cnt_o <= 32'h0;
		end else if (valid_i) begin
			cnt_o <= cnt_o + 32'h1;
			sof_cnt_o <= sof_cnt_o + {31'h0, sof_i};
			eof_cnt_o <= eof_cnt_o + {31'h0, eof_i};
			data_o <= data_i;
			nbits_o <= nbits_i;
			chan_o <= chan_i;
		end
	end
endmodule // mar_daq_sink

// File: mar_huff_enc.sv
// Purpose: lossless variable-length coder for 12-bit bipolar samples
// Assumes: decoder keeps the previous sample per channel
// Notes: code is right-aligned in code_o, nbits_o tells how many bits count
`timescale 1ns/1ps
module mar_huff_enc
	import mar_pkg::*;
(
	input wire logic [11:0] cur_i,
	input wire logic [11:0] prev_i,
	input wire logic force_raw_i,
	output logic [15:0] code_o,
	output logic [4:0] nbits_o
);
	// ------------------------------------------------------------
	// delta classes, short codes for the frequent small steps
	// ------------------------------------------------------------
	wire logic [11:0] delta = cur_i - prev_i;
	wire logic is_zero = (delta == 12'h000) && !force_raw_i;
	wire logic is_small = (delta[11:3] == 9'h000 || delta[11:3] == 9'h1ff) && !force_raw_i;
	wire logic is_mid = (delta[11:7] == 5'h00 || delta[11:7] == 5'h1f) && !force_raw_i;
	assign code_o = is_zero ? {14'h0000, MAR_PFX_ZERO} :
		is_small ? {10'h000, MAR_PFX_SMALL, delta[3:0]} :
		is_mid ? {6'h00, MAR_PFX_MID, delta[7:0]} :
		{2'h0, MAR_PFX_RAW, cur_i};
	assign nbits_o = is_zero ? MAR_NB_ZERO : is_small ? MAR_NB_SMALL :
		is_mid ? MAR_NB_MID : MAR_NB_RAW;
endmodule // mar_huff_enc

// File: mar_pkg.sv
// Purpose: shared constants for the multichannel adc readout datapath
// Assumes: apb register window, byte addresses, one 32-bit word per register
// Notes: control reset value selects 2.0 msps, 12 bit, continuous, no compression
package mar_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int MAR_NCHAN = 64;
	localparam int MAR_DECIM = 8;
	localparam int MAR_ADC_W = 14;
	localparam int MAR_NARROW_W = 12;
	localparam int MAR_OUT_W = 16;
	localparam int MAR_NB_W = 5;
	localparam int MAR_TS_W = 32;
	localparam int MAR_LEN_W = 16;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] MAR_CTRL_OFF = 8'h00;
	localparam logic [7:0] MAR_WIN_OFF = 8'h04;
	localparam logic [7:0] MAR_FRAME_OFF = 8'h08;
	localparam logic [7:0] MAR_STAT_OFF = 8'h0c;
	localparam logic [7:0] MAR_CNT_OFF = 8'h10;
	localparam logic [7:0] MAR_TRIG_OFF = 8'h14;
	localparam int MAR_CTRL_RATE_BIT = 0;
	localparam int MAR_CTRL_WIDE_BIT = 1;
	localparam int MAR_CTRL_COMP_BIT = 2;
	localparam int MAR_CTRL_TRIG_BIT = 3;
	localparam logic [3:0] MAR_CTRL_RST = 4'h0;
	localparam logic [15:0] MAR_WIN_RST = 16'h0400;
	localparam logic [15:0] MAR_FRAME_RST = 16'h0100;
	// ------------------------------------------------------------
	// compressed code: prefix, payload bits
	// ------------------------------------------------------------
	localparam logic [1:0] MAR_PFX_ZERO = 2'h0;
	localparam logic [1:0] MAR_PFX_SMALL = 2'h1;
	localparam logic [1:0] MAR_PFX_MID = 2'h2;
	localparam logic [1:0] MAR_PFX_RAW = 2'h3;
	localparam logic [4:0] MAR_NB_ZERO = 5'h02;
	localparam logic [4:0] MAR_NB_SMALL = 5'h06;
	localparam logic [4:0] MAR_NB_MID = 5'h0a;
	localparam logic [4:0] MAR_NB_RAW = 5'h0e;
	localparam logic [4:0] MAR_NB_12 = 5'h0c;
	localparam logic [4:0] MAR_NB_14 = 5'h0e;
	typedef enum logic [1:0] {MAR_IDLE, MAR_ARMED, MAR_WINDOW} mar_acq_t;
endpackage

// File: mar_readout.sv
// Purpose: per-channel decimation, width select, optional compression and framing of adc samples
// Assumes: adc words arrive channel-interleaved, synchronous to clk_i; ethernet/udp mac sits downstream
// Notes: apb slave answers with one wait state; unmapped addresses give pslverr
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
module mar_readout
	import mar_pkg::*;
#(
	parameter int NCHAN = MAR_NCHAN,
	parameter int DECIM = MAR_DECIM
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic adc_valid_i,
	input wire logic [$clog2(NCHAN)-1:0] adc_chan_i,
	input wire logic [MAR_ADC_W-1:0] adc_data_i,
	input wire logic sync_i,
	input wire logic ts_valid_i,
	input wire logic [MAR_TS_W-1:0] ts_i,
	input wire logic [MAR_TS_W-1:0] time_i,
	output logic rate_fast_o,
	output logic out_valid_o,
	output logic [MAR_OUT_W-1:0] out_data_o,
	output logic [MAR_NB_W-1:0] out_nbits_o,
	output logic [$clog2(NCHAN)-1:0] out_chan_o,
	output logic out_sof_o,
	output logic out_eof_o
);
	localparam int CW = $clog2(NCHAN);
	localparam int PW = $clog2(DECIM);

	if (NCHAN < 2 || NCHAN > 64 || (1 << CW) != NCHAN) begin : g_chk_nchan
		$error("NCHAN must be a power of two from 2 to 64");
	end
	if (DECIM < 2 || (1 << PW) != DECIM) begin : g_chk_decim
		$error("DECIM must be a power of two of at least 2");
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [3:0] ctrl_reg;
	logic [MAR_LEN_W-1:0] win_len_reg;
	logic [MAR_LEN_W-1:0] frame_len_reg;
	logic [31:0] word_total_reg;
	logic [MAR_TS_W-1:0] trig_ts_reg;
	logic [MAR_LEN_W-1:0] word_cnt_reg;
	mar_acq_t state_reg;
	logic [PW-1:0] phase_mem [NCHAN];
	logic [MAR_NARROW_W-1:0] prev_mem [NCHAN];
	logic [NCHAN-1:0] fresh_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic out_valid_reg;
	logic [MAR_OUT_W-1:0] out_data_reg;
	logic [MAR_NB_W-1:0] out_nbits_reg;
	logic [CW-1:0] out_chan_reg;
	logic out_sof_reg;
	logic out_eof_reg;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	wire logic apb_access = psel_i && penable_i;
	wire logic apb_done = apb_access && pready_reg;
	wire logic wr_en = apb_done && pwrite_i;
	wire logic hit_ctrl = (paddr_i == MAR_CTRL_OFF);
	wire logic hit_win = (paddr_i == MAR_WIN_OFF);
	wire logic hit_frame = (paddr_i == MAR_FRAME_OFF);
	wire logic hit_stat = (paddr_i == MAR_STAT_OFF);
	wire logic hit_cnt = (paddr_i == MAR_CNT_OFF);
	wire logic hit_trig = (paddr_i == MAR_TRIG_OFF);
	wire logic hit_any = hit_ctrl || hit_win || hit_frame || hit_stat || hit_cnt || hit_trig;
	logic [31:0] rd_mux;
	always_comb begin
		if (hit_ctrl) begin
			rd_mux = {28'h0000000, ctrl_reg};
		end else if (hit_win) begin
			rd_mux = {16'h0000, win_len_reg};
		end else if (hit_frame) begin
			rd_mux = {16'h0000, frame_len_reg};
		end else if (hit_stat) begin
			rd_mux = {14'h0000, state_reg, word_cnt_reg};
		end else if (hit_cnt) begin
			rd_mux = word_total_reg;
		end else if (hit_trig) begin
			rd_mux = trig_ts_reg;
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	// one wait state: the reply is registered during the first access cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= apb_access && !pready_reg;
			prdata_reg <= (apb_access && !pready_reg && !pwrite_i) ? rd_mux : 32'h00000000;
			pslverr_reg <= apb_access && !pready_reg && !hit_any;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= MAR_CTRL_RST;
			win_len_reg <= MAR_WIN_RST;
			frame_len_reg <= MAR_FRAME_RST;
		end else if (wr_en) begin
			if (hit_ctrl) begin
				ctrl_reg <= pwdata_i[3:0];
			end
			if (hit_win) begin
				win_len_reg <= pwdata_i[MAR_LEN_W-1:0];
			end
			if (hit_frame) begin
				frame_len_reg <= pwdata_i[MAR_LEN_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	wire logic mode_wide = ctrl_reg[MAR_CTRL_WIDE_BIT];
	wire logic mode_trig = ctrl_reg[MAR_CTRL_TRIG_BIT];
	// coding only defined for narrow samples; wide samples always pass raw
	wire logic mode_comp = ctrl_reg[MAR_CTRL_COMP_BIT] && !mode_wide;

	// ------------------------------------------------------------
	// decimation and sample shaping
	// ------------------------------------------------------------
	wire logic [PW-1:0] phase_sel = phase_mem[adc_chan_i];
	wire logic keep = adc_valid_i && (phase_sel == '0);
	// bipolar two's complement in and out, no offset removed or added
	wire logic [MAR_NARROW_W-1:0] narrow = adc_data_i[MAR_ADC_W-1:2];
	wire logic [MAR_OUT_W-1:0] wide_ext = {{2{adc_data_i[MAR_ADC_W-1]}}, adc_data_i};
	wire logic [MAR_OUT_W-1:0] narrow_ext = {{4{narrow[MAR_NARROW_W-1]}}, narrow};
	wire logic [15:0] enc_code;
	wire logic [4:0] enc_nbits;

	mar_huff_enc u_enc (
		.cur_i(narrow),
		.prev_i(prev_mem[adc_chan_i]),
		.force_raw_i(fresh_reg[adc_chan_i]),
		.code_o(enc_code),
		.nbits_o(enc_nbits)
	);

	// sync_i realigns every channel so all keep the same of eight samples
	always_ff @(posedge clk_i) begin
		if (rst_i || sync_i) begin
			for (int i = 0; i < NCHAN; i++) begin
				phase_mem[i] <= '0;
			end
		end else if (adc_valid_i) begin
			phase_mem[adc_chan_i] <= phase_sel + PW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NCHAN; i++) begin
				prev_mem[i] <= '0;
			end
		end else if (keep) begin
			prev_mem[adc_chan_i] <= narrow;
		end
	end

	// ------------------------------------------------------------
	// acquisition control
	// ------------------------------------------------------------
	// a limit of zero acts as one: every word closes its frame
	wire logic [MAR_TS_W-1:0] time_diff = time_i - trig_ts_reg;
	wire logic due = !time_diff[MAR_TS_W-1];
	wire logic pass = keep && (!mode_trig || state_reg == MAR_WINDOW);
	wire logic [MAR_LEN_W-1:0] limit = mode_trig ? win_len_reg : frame_len_reg;
	wire logic [MAR_LEN_W:0] cnt_inc = {1'b0, word_cnt_reg} + 17'h00001;
	wire logic last = (cnt_inc >= {1'b0, limit});
	wire logic first = (word_cnt_reg == '0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= MAR_IDLE;
			trig_ts_reg <= '0;
		end else if (!mode_trig) begin
			state_reg <= MAR_IDLE;
		end else begin
			case (state_reg)
				MAR_IDLE: begin
					if (ts_valid_i) begin
						state_reg <= MAR_ARMED;
						trig_ts_reg <= ts_i;
					end
				end
				MAR_ARMED: begin
					if (due) begin
						state_reg <= MAR_WINDOW;
					end
				end
				MAR_WINDOW: begin
					if (pass && last) begin
						state_reg <= MAR_IDLE;
					end
				end
				default: begin
					state_reg <= MAR_IDLE;
				end
			endcase
		end
	end

	// word counter frames both modes; only arming a new window restarts it, a mode change does not
	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg == MAR_ARMED) begin
			word_cnt_reg <= '0;
			fresh_reg <= '1;
		end else if (pass) begin
			word_cnt_reg <= last ? '0 : cnt_inc[MAR_LEN_W-1:0];
			// every frame restarts the coder so it decodes on its own
			fresh_reg <= last ? '1 : fresh_reg & ~(NCHAN'(1) << adc_chan_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			word_total_reg <= 32'h00000000;
		end else if (pass) begin
			word_total_reg <= word_total_reg + 32'h00000001;
		end
	end

	// ------------------------------------------------------------
	// output stage, handed to the udp framer on the 10 gbit/s link
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
			out_nbits_reg <= '0;
			out_chan_reg <= '0;
			out_sof_reg <= 1'b0;
			out_eof_reg <= 1'b0;
		end else begin
			out_valid_reg <= pass;
			out_sof_reg <= pass && first;
			out_eof_reg <= pass && last;
			if (pass) begin
				out_chan_reg <= adc_chan_i;
				if (mode_wide) begin
					out_data_reg <= wide_ext;
					out_nbits_reg <= MAR_NB_14;
				end else if (mode_comp) begin
					out_data_reg <= enc_code;
					out_nbits_reg <= enc_nbits;
				end else begin
					out_data_reg <= narrow_ext;
					out_nbits_reg <= MAR_NB_12;
				end
			end
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign rate_fast_o = ctrl_reg[MAR_CTRL_RATE_BIT];
	assign out_valid_o = out_valid_reg;
	assign out_data_o = out_data_reg;
	assign out_nbits_o = out_nbits_reg;
	assign out_chan_o = out_chan_reg;
	assign out_sof_o = out_sof_reg;
	assign out_eof_o = out_eof_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_reset_baseline: assert property ($fell(rst_i) |-> ctrl_reg == 4'h0 && !rate_fast_o)
		else $error("control not at baseline after reset");
	chk_keep_ratio: assert property (out_valid_o |-> $past(adc_valid_i) && $past(phase_sel) == '0)
		else $error("output word not from phase zero sample");
	chk_eight_apart: assert property (keep && !sync_i ##1 (adc_valid_i && adc_chan_i == $past(adc_chan_i))
		|-> !keep)
		else $error("channel kept twice inside one decimation cycle");
	chk_narrow_msb: assert property (out_valid_o && $past(!mode_wide && !mode_comp)
		|-> out_data_o[11:0] == $past(adc_data_i[13:2]) && out_nbits_o == 5'h0c)
		else $error("narrow sample not the top twelve bits");
	chk_wide_pass: assert property (out_valid_o && $past(mode_wide)
		|-> out_data_o[13:0] == $past(adc_data_i) && out_nbits_o == 5'h0e)
		else $error("wide sample altered");
	chk_sign_ext: assert property (out_valid_o && $past(!mode_comp)
		|-> out_data_o[15:14] == {2{out_data_o[13]}})
		else $error("bipolar sample not sign extended");
	chk_comp_narrow: assert property (out_valid_o && $past(ctrl_reg[MAR_CTRL_COMP_BIT] && mode_wide)
		|-> out_nbits_o == 5'h0e)
		else $error("wide sample was coded");
	chk_trig_gate: assert property (out_valid_o && $past(mode_trig) |-> $past(state_reg) == MAR_WINDOW)
		else $error("trigger mode word outside window");
	chk_window_open: assert property (mode_trig && state_reg == MAR_ARMED && due && !sync_i
		##1 mode_trig |-> state_reg == MAR_WINDOW)
		else $error("window not opened at trigger time");
	chk_frame_close: assert property (out_eof_o && $past(mode_trig) && mode_trig
		|-> state_reg == MAR_IDLE)
		else $error("window not closed with last frame word");
	chk_apb_wait: assert property (apb_access && !pready_o |=> pready_o)
		else $error("apb reply not after one wait state");

	cov_window: cover property (state_reg == MAR_ARMED ##1 state_reg == MAR_WINDOW ##[1:1000] out_eof_o);
	cov_coded: cover property (out_valid_o && out_nbits_o == 5'h02);
	cov_cont_frame: cover property (!mode_trig && out_eof_o);
	cov_wide: cover property (out_valid_o && out_nbits_o == 5'h0e && !mode_comp);
endmodule // mar_readout

// File: test_multichannel_adc_readout_datapath.sv
// Purpose: self-checking bench for the readout datapath
// Assumes: one wait state apb slave, output one cycle after a kept word
// Notes: seeded random samples with boundary deltas for the coder
`timescale 1ns/1ps
module test_multichannel_adc_readout_datapath;
	import mar_pkg::*;
	logic clk_i, rst_i, psel_i, penable_i, pwrite_i, adc_valid_i, sync_i, ts_valid_i;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, ts_i, time_i;
	logic pready_o, pslverr_o, rate_fast_o, out_valid_o, out_sof_o, out_eof_o;
	logic [5:0] adc_chan_i, out_chan_o, s_chan;
	logic [13:0] adc_data_i;
	logic [15:0] out_data_o, s_data;
	logic [4:0] out_nbits_o, s_nb;
	logic [31:0] s_cnt, s_sof, s_eof;
	int miscompares = 0;
	int checked = 0;
	int seed = 61846;
	mar_readout DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .adc_valid_i(adc_valid_i),
		.adc_chan_i(adc_chan_i), .adc_data_i(adc_data_i), .sync_i(sync_i), .ts_valid_i(ts_valid_i),
		.ts_i(ts_i), .time_i(time_i), .rate_fast_o(rate_fast_o), .out_valid_o(out_valid_o),
		.out_data_o(out_data_o), .out_nbits_o(out_nbits_o), .out_chan_o(out_chan_o),
		.out_sof_o(out_sof_o), .out_eof_o(out_eof_o));
	mar_daq_sink sink (.clk_i(clk_i), .rst_i(rst_i), .valid_i(out_valid_o), .data_i(out_data_o),
		.nbits_i(out_nbits_o), .chan_i(out_chan_o), .sof_i(out_sof_o), .eof_i(out_eof_o),
		.cnt_o(s_cnt), .sof_cnt_o(s_sof), .eof_cnt_o(s_eof), .data_o(s_data), .nbits_o(s_nb),
		.chan_o(s_chan));
	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		#(40 * 8000);
		miscompares++;
		final_report();
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic final_report();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// no wait count assumed: only the watchdog ends a hung transfer
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic pulse(input int which);
		@(posedge clk_i);
		if (which == 0) sync_i <= 1'b1;
		else ts_valid_i <= 1'b1;
		@(posedge clk_i);
		sync_i <= 1'b0;
		ts_valid_i <= 1'b0;
	endtask
	task automatic send(input logic [5:0] c, input logic [13:0] d);
		@(posedge clk_i);
		adc_valid_i <= 1'b1;
		adc_chan_i <= c;
		adc_data_i <= d;
		@(posedge clk_i);
		adc_valid_i <= 1'b0;
	endtask
	// one kept word, then fillers through the rest of the phase
	// back to back, so a channel is offered on consecutive cycles
	task automatic group(input logic [5:0] c, input logic [13:0] d);
		@(posedge clk_i);
		adc_valid_i <= 1'b1;
		adc_chan_i <= c;
		adc_data_i <= d;
		repeat (7) begin
			@(posedge clk_i);
			adc_data_i <= 14'($random(seed));
		end
		@(posedge clk_i);
		adc_valid_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	function automatic logic [20:0] code(input logic [11:0] cur, input logic [11:0] prev);
		logic [11:0] d;
		d = cur - prev;
		if (d == 12'h0) return {5'h02, 16'h0};
		if ($signed(d) >= -8 && $signed(d) <= 7) return {5'h06, 10'h0, 2'h1, d[3:0]};
		if ($signed(d) >= -128 && $signed(d) <= 127) return {5'h0a, 6'h0, 2'h2, d[7:0]};
		return {5'h0e, 2'h0, 2'h3, cur};
	endfunction
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		logic [31:0] v, n0, s0, e0;
		logic e;
		logic [13:0] d;
		logic [11:0] prev, cur;
		logic [20:0] x;
		logic [11:0] dt [8];
		dt = '{12'h000, 12'hffb, 12'h007, 12'h008, 12'hf80, 12'h07f, 12'hf7f, 12'h5dc};
		{psel_i, penable_i, pwrite_i, adc_valid_i, sync_i, ts_valid_i} = 6'h0;
		{paddr_i, pwdata_i, ts_i, time_i, adc_chan_i, adc_data_i} = '0;
		rst_i = 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		apb(1'b0, MAR_CTRL_OFF, 32'h0, v, e);
		chk("ctrl", 32'h0, v);
		chk("rate", 32'h0, {31'h0, rate_fast_o});
		apb(1'b0, MAR_WIN_OFF, 32'h0, v, e);
		chk("window", 32'h400, v);
		apb(1'b0, MAR_FRAME_OFF, 32'h0, v, e);
		chk("frame", 32'h100, v);
		apb(1'b0, 8'h3c, 32'h0, v, e);
		chk("unmapped", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, v);
		wr(MAR_CTRL_OFF, 32'h1);
		#1;
		chk("rate", 32'h1, {31'h0, rate_fast_o});
		$display("test registers done");
		for (int w = 0; w < 2; w++) begin
			wr(MAR_CTRL_OFF, (w == 1) ? 32'h2 : 32'h0);
			pulse(0);
			for (int k = 0; k < 32; k++) begin
				n0 = s_cnt;
				d = 14'($random(seed));
				send(k[0] ? 6'h09 : 6'h05, d);
				repeat (2) @(posedge clk_i);
				#1;
				if (k[3:1] == 3'h0) begin
					chk("count", n0 + 1, s_cnt);
					chk("chan", k[0] ? 32'h9 : 32'h5, {26'h0, s_chan});
					chk("sample", (w == 1) ? {{18{d[13]}}, d} : {{20{d[13]}}, d[13:2]},
						{{16{s_data[15]}}, s_data});
					chk("width", (w == 1) ? 32'he : 32'hc, {27'h0, s_nb});
				end else begin
					chk("count", n0, s_cnt);
				end
			end
		end
		$display("test decimation done");
		wr(MAR_CTRL_OFF, 32'h4);
		pulse(0);
		prev = 12'($random(seed));
		group(6'h03, {prev, 2'h1});
		chk("raw", {18'h0, 2'h3, prev}, {16'h0, s_data});
		for (int i = 0; i < 8; i++) begin
			cur = prev + dt[i];
			group(6'h03, {cur, 2'($random(seed))});
			x = code(cur, prev);
			chk("nbits", {27'h0, x[20:16]}, {27'h0, s_nb});
			chk("code", {16'h0, x[15:0]}, {16'h0, s_data});
			prev = cur;
		end
		// coding asked for with wide samples: wide samples pass raw
		wr(MAR_CTRL_OFF, 32'h6);
		d = 14'($random(seed));
		group(6'h03, d);
		chk("coded wide", {{18{d[13]}}, d}, {{16{s_data[15]}}, s_data});
		chk("coded wide nbits", 32'he, {27'h0, s_nb});
		$display("test compression done");
		wr(MAR_WIN_OFF, 32'h3);
		wr(MAR_CTRL_OFF, 32'h8);
		n0 = s_cnt;
		group(6'h02, 14'h1234);
		chk("idle drop", n0, s_cnt);
		@(posedge clk_i);
		ts_i <= 32'h100;
		pulse(1);
		apb(1'b0, MAR_STAT_OFF, 32'h0, v, e);
		chk("armed", 32'h1, {30'h0, v[17:16]});
		apb(1'b0, MAR_TRIG_OFF, 32'h0, v, e);
		chk("trigger time", 32'h100, v);
		group(6'h02, 14'h0abc);
		chk("armed drop", n0, s_cnt);
		@(posedge clk_i);
		time_i <= 32'h100;
		repeat (2) @(posedge clk_i);
		s0 = s_sof;
		e0 = s_eof;
		repeat (4) group(6'h02, 14'($random(seed)));
		chk("window words", n0 + 3, s_cnt);
		chk("window sof", s0 + 1, s_sof);
		chk("window eof", e0 + 1, s_eof);
		apb(1'b0, MAR_CNT_OFF, 32'h0, v, e);
		chk("word total", s_cnt, v);
		$display("test trigger done");
		final_report();
	end
endmodule // test_multichannel_adc_readout_datapath
